//--- rtl/line_coder_pkg.sv
// shared constants, code-groups and 4B/5B lookup for the line coder
package line_coder_pkg;
  // timing
  localparam int CLK_NS      = 10;
  localparam int SD_QUAL_NS  = 1000;
  localparam int SD_QUAL_CYC = (SD_QUAL_NS + CLK_NS - 1) / CLK_NS;
  // scrambler x^11 + x^9 + 1
  localparam int LFSR_W           = 11;
  localparam int LFSR_TAP_A       = 10;
  localparam int LFSR_TAP_B       = 8;
  localparam logic [10:0] LFSR_SEED = 11'h7FF;
  localparam int LOCK_RUN         = 60;
  // symbol framing
  localparam int SYM_W            = 5;
  localparam logic [2:0] SYM_LAST = 3'h4;
  // fifo word: {enable, error, 5-bit data}
  localparam int WORD_W = 7;
  localparam int W_EN   = 6;
  localparam int W_ER   = 5;
  // control code-groups
  localparam logic [4:0] SYM_I = 5'h1F;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_H = 5'h04;
  localparam logic [9:0] SYM_JK = {SYM_J, SYM_K};
  localparam logic [3:0] NIB_PRE  = 4'h5;
  localparam logic [3:0] NIB_ZERO = 4'h0;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_J    = 3'b001,
    TX_DATA = 3'b010,
    TX_T    = 3'b011
  } tx_state_t;

  // nibble to data code-group
  function automatic logic [4:0] enc4b5b(input logic [3:0] nib);
    logic [4:0] s;
    s = SYM_I;
    unique case (nib)
      4'h0: s = 5'h1E;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0A;
      4'h5: s = 5'h0B;
      4'h6: s = 5'h0E;
      4'h7: s = 5'h0F;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'hA: s = 5'h16;
      4'hB: s = 5'h17;
      4'hC: s = 5'h1A;
      4'hD: s = 5'h1B;
      4'hE: s = 5'h1C;
      4'hF: s = 5'h1D;
    endcase
    return s;
  endfunction : enc4b5b

  // data code-group to {valid, nibble}; controls and invalids give valid low
  function automatic logic [4:0] dec5b4b(input logic [4:0] s);
    logic [4:0] r;
    r = {1'b0, NIB_ZERO};
    for (int i = 0; i < 16; i++) begin
      if (enc4b5b(4'(i)) == s) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : dec5b4b
endpackage : line_coder_pkg

//--- rtl/sym_stream_if.sv
// valid/ready word stream between the coder's internal modules
`timescale 1ns/1ps
`default_nettype none
interface sym_stream_if #(parameter int W = 7);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : sym_stream_if
`default_nettype wire

//--- rtl/word_fifo.sv
// small synchronous fifo, registered full flag drives the fill-side ready
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int W = 7,
  parameter int DEPTH = 4
) (
  input wire logic     clk,
  input wire logic     rst,
  sym_stream_if.snk    wr,
  sym_stream_if.src    rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          nfull_r;
  logic          push;
  logic          pop;

  assign push     = wr.valid && nfull_r;
  assign pop      = rd.ready && (cnt_r != '0);
  assign wr.ready = nfull_r;
  assign rd.valid = (cnt_r != '0);
  assign rd.data  = mem[rp_r];

  // occupancy; ready drops one word early is avoided by using next count
  always_comb begin
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r    <= '0;
      rp_r    <= '0;
      cnt_r   <= '0;
      nfull_r <= 1'b0; // not ready while held in reset
    end else begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)  rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r   <= cnt_nxt;
      nfull_r <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end

  // storage needs no reset
  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= wr.data;
  end
endmodule : word_fifo
`default_nettype wire

//--- rtl/rx_sym_decoder.sv
// receive code-group decoder: aligned 5-bit symbols to nibbles and flags
`timescale 1ns/1ps
`default_nettype none
module rx_sym_decoder
  import line_coder_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        bypass,
  sym_stream_if.snk       sym,
  output logic [4:0]      rxd,
  output logic            rx_dv,
  output logic            rx_er,
  output logic            rx_inv,
  output logic            rx_stb
);
  logic       in_pkt_r;
  logic [4:0] dv;

  assign sym.ready = 1'b1;
  assign dv = dec5b4b(sym.data[4:0]);

  // one output per received symbol, strobe marks it
  always_ff @(posedge clk) begin
    if (rst) begin
      in_pkt_r <= 1'b0;
      rxd      <= '0;
      rx_dv    <= 1'b0;
      rx_er    <= 1'b0;
      rx_inv   <= 1'b0;
      rx_stb   <= 1'b0;
    end else begin
      rx_stb <= sym.valid;
      if (sym.valid) begin
        rx_er  <= 1'b0;
        rx_inv <= 1'b0;
        if (bypass) begin
          rxd   <= sym.data[4:0]; // RULE_14
          rx_dv <= 1'b1;
        end else begin
          unique case (sym.data[4:0])
            SYM_J, SYM_K: begin
              in_pkt_r <= 1'b1;
              rxd      <= {1'b0, NIB_PRE}; // RULE_07 RULE_08
              rx_dv    <= 1'b1;
            end
            SYM_T, SYM_R, SYM_I: begin
              in_pkt_r <= 1'b0; // RULE_06 RULE_09 RULE_10
              rxd      <= {1'b0, NIB_ZERO};
              rx_dv    <= 1'b0;
            end
            SYM_H: begin
              rxd   <= {1'b0, NIB_ZERO};
              rx_dv <= in_pkt_r;
              rx_er <= 1'b1; // RULE_11
            end
            default: begin
              rxd    <= {1'b0, dv[3:0]}; // RULE_05
              rx_dv  <= in_pkt_r;
              rx_er  <= !dv[4];
              rx_inv <= !dv[4]; // RULE_20
            end
          endcase
        end
      end
    end
  end
endmodule : rx_sym_decoder
`default_nettype wire

//--- rtl/fe_line_coder.sv
// 100 Mb/s line coder: 4B/5B, scrambler, NRZI, three-level split, receive path
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE_01] scrambling sequence from free-running 11-bit LFSR on symbol clock; the code steps it on every REF_CLK bit clock
// [RULE_02] each LFSR bit XORs one serial code-group bit
// [RULE_03] NRZI encoding always applied, toggle on every one, no bypass
// [RULE_04] NRZI stream split into two outputs whose ones alternate
// [RULE_05] nibbles map to the sixteen 4B/5B data code-groups and back
// [RULE_06] 11111 is idle, decodes to 0000, never packet data
// [RULE_07] 11000 is first start delimiter, preamble nibble 0101
// [RULE_08] 10001 is second start delimiter, preamble nibble 0101
// [RULE_09] 01101 is first end delimiter, nibble 0000
// [RULE_10] 00111 is second end delimiter, nibble 0000
// [RULE_11] 00100 is halt, signals and propagates transmit errors
// [RULE_12] only three-level line output exists, no binary mode
// [RULE_13] receive stream becomes synchronous 4-bit nibbles to the MAC
// [RULE_14] receive descrambler and decoder are each bypassable
// [RULE_15] link pulses never raise signal detect
// [RULE_16] first two preamble nibbles replaced by J/K pair
// [RULE_17] transmit enable low appends T then R
// [RULE_18] idles sent after T/R until next packet
// [RULE_19] transmit encoder and scrambler each bypassable
// [RULE_20] unassigned patterns never sent, flagged invalid on receive
// [RULE_21] scrambler polynomial is x^11 + x^9 + 1
module fe_line_coder
  import line_coder_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input  wire logic         REF_CLK,
  input  wire logic         RST,
  // mac transmit side
  input  wire logic [4:0]   TXD,
  input  wire logic         TX_EN,
  input  wire logic         TX_ER,
  input  wire logic         TX_VALID,
  output logic              TX_READY,
  // stage bypass controls
  input  wire logic         ENC_BYPASS,
  input  wire logic         SCR_BYPASS,
  input  wire logic         DESCR_BYPASS,
  input  wire logic         DEC_BYPASS,
  // line driver
  output logic              TX_POS,
  output logic              TX_NEG,
  // line receiver
  input  wire logic         RX_NRZI,
  input  wire logic         RX_SD_IN,
  // mac receive side
  output logic [4:0]        RXD,
  output logic              RX_DV,
  output logic              RX_ER,
  output logic              RX_INVALID,
  output logic              RX_STB,
  output logic              SIG_DET,
  output logic              DESCR_LOCK
);
  import line_coder_pkg::*;

  sym_stream_if #(.W(WORD_W)) mac_if ();
  sym_stream_if #(.W(WORD_W)) enc_if ();
  sym_stream_if #(.W(SYM_W))  rsym_if ();

  // transmit state
  tx_state_t          st_r;
  tx_state_t          st_nxt;
  logic [2:0]         bcnt_r;
  logic [4:0]         sh_r;
  logic [4:0]         sym_nxt;
  logic               pop;
  logic [10:0]        lfsr_r;
  logic               tx_fb;
  logic               sbit;
  logic               nrzi_r;
  logic               nrzi_nxt;
  logic [1:0]         phase_r;
  logic [1:0]         phase_nxt;
  // receive state
  logic [2:0]         rx_s_r;
  logic [2:0]         sd_s_r;
  logic               rx_lvl_r;
  logic               rx_prev_r;
  logic               sd_lvl_r;
  logic [7:0]         sd_cnt_r;
  logic               sig_det_r;
  logic               nrz;
  logic [10:0]        dl_r;
  logic               rx_fb;
  logic               ud;
  logic [6:0]         run_r;
  logic               lock_r;
  logic [9:0]         win_r;
  logic [9:0]         win_nxt;
  logic               aligned_r;
  logic [2:0]         acnt_r;
  logic               pend_k_r;
  logic [4:0]         rsym_r;
  logic               rvalid_r;

  // mac words enter the fifo; ready comes from its registered flag
  assign mac_if.data  = {TX_EN, TX_ER, TXD};
  assign mac_if.valid = TX_VALID;
  assign enc_if.ready = pop;

  word_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk (REF_CLK),
    .rst (RST),
    .wr  (mac_if),
    .rd  (enc_if)
  );

  // ready is the fifo's own full flop, so a word shown as taken is always stored
  assign TX_READY = mac_if.ready;

  // next code-group, chosen at each symbol boundary
  always_comb begin
    st_nxt  = st_r;
    sym_nxt = SYM_I; // RULE_18
    pop     = 1'b0;
    if (bcnt_r == SYM_LAST) begin
      if (ENC_BYPASS) begin
        st_nxt = TX_IDLE;
        if (enc_if.valid) begin
          pop     = 1'b1;
          sym_nxt = enc_if.data[4:0]; // RULE_19
        end
      end else begin
        unique case (st_r)
          TX_IDLE: begin
            if (enc_if.valid) begin
              pop = 1'b1;
              if (enc_if.data[W_EN]) begin
                sym_nxt = SYM_J; // RULE_16 RULE_07
                st_nxt  = TX_J;
              end
            end
          end
          TX_J: begin
            pop     = enc_if.valid;
            sym_nxt = SYM_K; // RULE_16 RULE_08
            st_nxt  = TX_DATA;
          end
          TX_DATA: begin
            if (!enc_if.valid) begin
              sym_nxt = SYM_H; // underrun corrupts the frame
            end else if (!enc_if.data[W_EN]) begin
              pop     = 1'b1;
              sym_nxt = SYM_T; // RULE_17 RULE_09
              st_nxt  = TX_T;
            end else begin
              pop     = 1'b1;
              sym_nxt = enc_if.data[W_ER] ? SYM_H : enc4b5b(enc_if.data[3:0]); // RULE_11 RULE_05 RULE_20
            end
          end
          TX_T: begin
            sym_nxt = SYM_R; // RULE_17 RULE_10
            st_nxt  = TX_IDLE;
          end
          default: begin
            st_nxt = TX_IDLE;
          end
        endcase
      end
    end
  end

  // tx sequencer state
  always_ff @(posedge REF_CLK) begin
    if (RST) st_r <= TX_IDLE;
    else     st_r <= st_nxt;
  end

  // serialiser, msb of the code-group first
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      bcnt_r <= '0;
      sh_r   <= SYM_I;
    end else if (bcnt_r == SYM_LAST) begin
      bcnt_r <= '0;
      sh_r   <= sym_nxt;
    end else begin
      bcnt_r <= bcnt_r + 3'h1;
      sh_r   <= {sh_r[3:0], 1'b0};
    end
  end

  // scrambler lfsr free-runs every clock regardless of bypass
  assign tx_fb = lfsr_r[LFSR_TAP_A] ^ lfsr_r[LFSR_TAP_B]; // RULE_21
  assign sbit  = sh_r[4] ^ (tx_fb & !SCR_BYPASS); // RULE_02 RULE_19

  always_ff @(posedge REF_CLK) begin
    if (RST) lfsr_r <= LFSR_SEED;
    else     lfsr_r <= {lfsr_r[9:0], tx_fb}; // RULE_01
  end

  // nrzi: line level toggles on every one, no bypass path exists
  assign nrzi_nxt = nrzi_r ^ sbit; // RULE_03

  always_ff @(posedge REF_CLK) begin
    if (RST) nrzi_r <= 1'b0;
    else     nrzi_r <= nrzi_nxt;
  end

  // three-level split: each transition advances the phase,
  // phase 1 drives positive side, phase 3 negative side
  assign phase_nxt = phase_r + {1'b0, nrzi_nxt ^ nrzi_r};

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      phase_r <= '0;
      TX_POS  <= 1'b0;
      TX_NEG  <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      TX_POS  <= (phase_nxt == 2'h1); // RULE_04 RULE_12
      TX_NEG  <= (phase_nxt == 2'h3); // RULE_04 RULE_12
    end
  end

  // pin synchronisers; the signal detect level counts once stages two and three agree
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rx_s_r <= '0;
      sd_s_r <= '0;
    end else begin
      rx_s_r <= {rx_s_r[1:0], RX_NRZI};
      sd_s_r <= {sd_s_r[1:0], RX_SD_IN};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rx_lvl_r  <= 1'b0;
      rx_prev_r <= 1'b0;
      sd_lvl_r  <= 1'b0;
    end else begin
      rx_lvl_r <= rx_s_r[2]; // one bit per clock, no time to wait for agreement
      if (sd_s_r[1] == sd_s_r[2]) sd_lvl_r <= sd_s_r[2];
      rx_prev_r <= rx_lvl_r;
    end
  end

  // signal detect must hold far longer than any link pulse
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sd_cnt_r  <= '0;
      sig_det_r <= 1'b0;
    end else if (!sd_lvl_r) begin
      sd_cnt_r  <= '0;
      sig_det_r <= 1'b0;
    end else if (sd_cnt_r == 8'(SD_QUAL_CYC - 1)) begin
      sig_det_r <= 1'b1; // RULE_15
    end else begin
      sd_cnt_r <= sd_cnt_r + 8'h01;
    end
  end
  assign SIG_DET = sig_det_r;

  // nrzi to nrz, then descramble
  assign nrz   = rx_lvl_r ^ rx_prev_r;
  assign rx_fb = dl_r[LFSR_TAP_A] ^ dl_r[LFSR_TAP_B];
  assign ud    = DESCR_BYPASS ? nrz : (nrz ^ rx_fb); // RULE_14

  // lock: during idle the line carries inverted key bits, so load them,
  // then declare lock after a run of correctly predicted bits
  always_ff @(posedge REF_CLK) begin
    if (RST || !sig_det_r) begin
      dl_r   <= LFSR_SEED;
      run_r  <= '0;
      lock_r <= 1'b0;
    end else if (lock_r) begin
      dl_r <= {dl_r[9:0], rx_fb};
    end else begin
      dl_r <= {dl_r[9:0], !nrz};
      if (!nrz == rx_fb) begin
        run_r <= run_r + 7'h01;
        if (run_r == 7'(LOCK_RUN - 1)) lock_r <= 1'b1;
      end else begin
        run_r <= '0;
      end
    end
  end
  assign DESCR_LOCK = lock_r;

  // code-group alignment on J/K, released on idle or the second end delimiter R
  assign win_nxt = {win_r[8:0], ud};

  always_ff @(posedge REF_CLK) begin
    if (RST || !sig_det_r) begin
      win_r     <= '0;
      aligned_r <= 1'b0;
      acnt_r    <= '0;
      pend_k_r  <= 1'b0;
      rsym_r    <= SYM_I;
      rvalid_r  <= 1'b0;
    end else begin
      win_r    <= win_nxt;
      rvalid_r <= 1'b0;
      pend_k_r <= 1'b0;
      if (pend_k_r) begin
        rsym_r   <= SYM_K;
        rvalid_r <= 1'b1;
      end
      if (!aligned_r) begin
        if (win_nxt == SYM_JK) begin
          aligned_r <= 1'b1;
          acnt_r    <= '0;
          rsym_r    <= SYM_J;
          rvalid_r  <= 1'b1;
          pend_k_r  <= 1'b1;
        end
      end else if (acnt_r == SYM_LAST) begin
        acnt_r   <= '0;
        rsym_r   <= win_nxt[4:0]; // RULE_13
        rvalid_r <= 1'b1;
        if (win_nxt[4:0] == SYM_R || win_nxt[4:0] == SYM_I) aligned_r <= 1'b0;
      end else begin
        acnt_r <= acnt_r + 3'h1;
      end
    end
  end

  assign rsym_if.data  = rsym_r;
  assign rsym_if.valid = rvalid_r;

  rx_sym_decoder u_dec (
    .clk    (REF_CLK),
    .rst    (RST),
    .bypass (DEC_BYPASS),
    .sym    (rsym_if),
    .rxd    (RXD),
    .rx_dv  (RX_DV),
    .rx_er  (RX_ER),
    .rx_inv (RX_INVALID),
    .rx_stb (RX_STB)
  );
endmodule : fe_line_coder
`default_nettype wire

//--- dv/line_partner.sv
// line-side model: loops the three-level transmit line back and fakes energy detect
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  // clock
  input  wire logic       clk,
  // three-level line from the driver
  input  wire logic       tx_pos,
  input  wire logic       tx_neg,
  // 0 no energy, 1 short link-pulse bursts, 2 steady signal
  input  wire logic [1:0] sd_mode,
  // receiver side
  output logic            rx_nrzi,
  output logic            rx_sd
);
  logic [1:0] lvl_r;
  logic [8:0] pulse_cnt;

  initial begin
    rx_nrzi   = 1'b0;
    rx_sd     = 1'b0;
    lvl_r     = 2'b00;
    pulse_cnt = 9'h000;
  end

  // any change of line level is a one; nrzi toggles on ones
  always @(negedge clk) begin
    rx_nrzi <= rx_nrzi ^ ({tx_pos, tx_neg} != lvl_r);
    lvl_r   <= {tx_pos, tx_neg};
  end

  // bursts far shorter than the qualify time, like link pulses
  always @(negedge clk) begin
    pulse_cnt <= pulse_cnt + 9'h001;
    case (sd_mode)
      2'h1: rx_sd <= (pulse_cnt < 9'h020);
      2'h2: rx_sd <= 1'b1;
      default: rx_sd <= 1'b0;
    endcase
  end
endmodule : line_partner
`default_nettype wire

//--- dv/fe_line_coder_monitor.sv
// concurrent checks on the line coder's top-level ports
`timescale 1ns/1ps
`default_nettype none
module fe_line_coder_monitor (
  // clock and reset
  input wire logic       REF_CLK,
  input wire logic       RST,
  // observed ports
  input wire logic       TX_POS,
  input wire logic       TX_NEG,
  input wire logic       RX_SD_IN,
  input wire logic       DEC_BYPASS,
  input wire logic [4:0] RXD,
  input wire logic       RX_DV,
  input wire logic       RX_ER,
  input wire logic       RX_INVALID,
  input wire logic       RX_STB,
  input wire logic       SIG_DET,
  input wire logic       DESCR_LOCK
);
  import line_coder_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  localparam int SD_MIN = SD_QUAL_CYC - 1;
  logic [7:0] sd_run_r;
  logic       last_neg_r;

  // raw energy run length, saturating so long links do not wrap
  always_ff @(posedge REF_CLK) begin
    if (RST || !RX_SD_IN) sd_run_r <= 8'h00;
    else if (sd_run_r != 8'hFF) sd_run_r <= sd_run_r + 8'h01;
  end

  // polarity of the last non-zero line level; phase restarts toward plus
  always_ff @(posedge REF_CLK) begin
    if (RST) last_neg_r <= 1'b1;
    else if (TX_NEG) last_neg_r <= 1'b1;
    else if (TX_POS) last_neg_r <= 1'b0;
  end

  property p_no_both;     !(TX_POS && TX_NEG); endproperty
  property p_pos_alt;     $rose(TX_POS) |-> last_neg_r; endproperty
  property p_neg_alt;     $rose(TX_NEG) |-> !last_neg_r; endproperty
  property p_sd_qual;     $rose(SIG_DET) |-> sd_run_r >= SD_MIN; endproperty
  property p_sd_drop;     !RX_SD_IN [*8] |-> !SIG_DET; endproperty
  property p_stb_need_sd; !SIG_DET [*4] |-> !RX_STB; endproperty
  property p_lock_need_sd;!SIG_DET [*3] |=> !DESCR_LOCK; endproperty
  property p_inv_err;     RX_INVALID |-> RX_ER; endproperty
  property p_hold;        !RX_STB |-> $stable({RXD, RX_DV, RX_ER, RX_INVALID}); endproperty
  property p_nibble;      RX_STB && RX_DV && !DEC_BYPASS |-> RXD[4] == 1'b0; endproperty
  property p_stb_gap;     RX_STB ##1 RX_STB |=> !RX_STB [*3] ##1 RX_STB; endproperty

  a_no_both: assert property (p_no_both) else $error("both line drives high");
  a_pos_alt: assert property (p_pos_alt) else $error("plus level repeated");
  a_neg_alt: assert property (p_neg_alt) else $error("minus level repeated");
  a_sd_qual: assert property (p_sd_qual) else $error("signal detect too early");
  a_sd_drop: assert property (p_sd_drop) else $error("signal detect stuck high");
  a_stb_need_sd: assert property (p_stb_need_sd) else $error("decode without signal");
  a_lock_need_sd: assert property (p_lock_need_sd) else $error("lock without signal");
  a_inv_err: assert property (p_inv_err) else $error("invalid without error");
  a_hold: assert property (p_hold) else $error("receive outputs moved off strobe");
  a_nibble: assert property (p_nibble) else $error("nibble wider than 4 bits");
  a_stb_gap: assert property (p_stb_gap) else $error("strobe spacing wrong");

  c_lock: cover property ($rose(DESCR_LOCK));
  c_data: cover property (RX_STB && RX_DV);
  c_inv:  cover property (RX_STB && RX_INVALID);
endmodule : fe_line_coder_monitor

bind fe_line_coder fe_line_coder_monitor i_mon (
  .REF_CLK(REF_CLK), .RST(RST), .TX_POS(TX_POS), .TX_NEG(TX_NEG), .RX_SD_IN(RX_SD_IN),
  .DEC_BYPASS(DEC_BYPASS), .RXD(RXD), .RX_DV(RX_DV), .RX_ER(RX_ER), .RX_INVALID(RX_INVALID),
  .RX_STB(RX_STB), .SIG_DET(SIG_DET), .DESCR_LOCK(DESCR_LOCK)
);
`default_nettype wire

//--- dv/tb.sv
// self-checking bench: transmit line looped back into the receive path
`timescale 1ns/1ps
`default_nettype none
module tb;
  import line_coder_pkg::*;
  logic       clk, rst, tx_en, tx_er, tx_valid, tx_ready, refused;
  logic [4:0] txd, rxd;
  logic       enc_byp, scr_byp, descr_byp, dec_byp, tx_pos, tx_neg, rx_nrzi, rx_sd;
  logic       rx_dv, rx_er, rx_inv, rx_stb, sig_det, lock;
  logic [1:0] sd_mode;
  logic [7:0] rxq[$];
  int         num_errors, n_checks, cyc;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  fe_line_coder #(.FIFO_DEPTH(4)) i_dut (
    .REF_CLK(clk), .RST(rst), .TXD(txd), .TX_EN(tx_en), .TX_ER(tx_er), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .ENC_BYPASS(enc_byp), .SCR_BYPASS(scr_byp), .DESCR_BYPASS(descr_byp),
    .DEC_BYPASS(dec_byp), .TX_POS(tx_pos), .TX_NEG(tx_neg), .RX_NRZI(rx_nrzi), .RX_SD_IN(rx_sd),
    .RXD(rxd), .RX_DV(rx_dv), .RX_ER(rx_er), .RX_INVALID(rx_inv), .RX_STB(rx_stb),
    .SIG_DET(sig_det), .DESCR_LOCK(lock)
  );
  line_partner i_line (.clk(clk), .tx_pos(tx_pos), .tx_neg(tx_neg), .sd_mode(sd_mode),
    .rx_nrzi(rx_nrzi), .rx_sd(rx_sd));

  // log every decoded symbol as {dv, er, invalid, rxd}
  always @(negedge clk) begin
    if (rx_stb === 1'b1) rxq.push_back({rx_dv, rx_er, rx_inv, rxd});
  end

  // hang guard, runs far beyond the expected few thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    n_checks++;
    if ((got & msk) !== (exp & msk)) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  // holds the word until the edge that sees ready high
  task automatic send_word(input logic en, input logic er, input logic [4:0] d);
    txd = d;
    tx_en = en;
    tx_er = er;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) begin
      refused = 1'b1;
      @(negedge clk);
    end
    @(negedge clk);
  endtask : send_word

  task automatic send_pkt(input logic [4:0] d[$], input int er_at, input logic fin);
    foreach (d[i]) send_word(1'b1, i == er_at, d[i]);
    if (fin) send_word(1'b0, 1'b0, 5'h00);
    tx_valid = 1'b0;
  endtask : send_pkt

  task automatic expect_rx(input logic [7:0] e[$], input logic [7:0] m[$]);
    repeat (800) if (rxq.size() < e.size()) @(negedge clk);
    check(8'(rxq.size() >= e.size()), 8'h01, 8'hFF);
    foreach (e[i]) if (i < rxq.size()) check(rxq[i], e[i], (i < m.size()) ? m[i] : 8'hFF);
  endtask : expect_rx

  task automatic t_pulses();
    logic hit;
    hit = 1'b0;
    sd_mode = 2'h1;
    repeat (2000) begin
      @(negedge clk);
      if (sig_det !== 1'b0) hit = 1'b1;
    end
    check({7'h00, hit}, 8'h00, 8'hFF);
    sd_mode = 2'h2;
    repeat (1500) if (lock !== 1'b1) @(negedge clk);
    check({6'h00, sig_det, lock}, 8'h03, 8'hFF);
    $display("test link pulses done");
  endtask : t_pulses

  task automatic t_data();
    logic [4:0] d[$];
    logic [7:0] e[$];
    int         n;
    rxq.delete();
    refused = 1'b0;
    d = '{5'h05, 5'h05};
    e = '{8'h85, 8'h85};
    for (int i = 0; i < 16; i++) begin
      d.push_back(5'(i));
      e.push_back(8'h80 | 8'(i));
    end
    e.push_back(8'h00);
    send_pkt(d, -1, 1'b1);
    expect_rx(e, '{});
    check({7'h00, refused}, 8'h01, 8'hFF);
    repeat (50) @(negedge clk);
    n = rxq.size();
    repeat (300) @(negedge clk);
    check(8'(rxq.size()), 8'(n), 8'hFF);
    $display("test data packet done");
  endtask : t_data

  task automatic t_halt();
    rxq.delete();
    send_pkt('{5'h05, 5'h05, 5'h0A, 5'h03}, 2, 1'b1);
    expect_rx('{8'h85, 8'h85, 8'h40, 8'h83, 8'h00}, '{8'hFF, 8'hFF, 8'h40});
    repeat (100) @(negedge clk);
    $display("test halt done");
  endtask : t_halt

  task automatic t_encbyp();
    rxq.delete();
    enc_byp = 1'b1;
    send_pkt('{SYM_J, SYM_K, 5'h00, 5'h09, SYM_T, SYM_R}, -1, 1'b0);
    expect_rx('{8'h85, 8'h85, 8'h60, 8'h81, 8'h00}, '{8'hFF, 8'hFF, 8'h60});
    repeat (100) @(negedge clk);
    enc_byp = 1'b0;
    $display("test encoder bypass done");
  endtask : t_encbyp

  task automatic t_allbyp();
    scr_byp = 1'b1;
    descr_byp = 1'b1;
    dec_byp = 1'b1;
    repeat (100) @(negedge clk);
    rxq.delete();
    send_pkt('{5'h05, 5'h05, 5'h07}, -1, 1'b1);
    expect_rx('{8'h98, 8'h91, 8'h8F}, '{8'h9F, 8'h9F, 8'h9F});
    $display("test stage bypass done");
  endtask : t_allbyp

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // reset held four edges, then the scenarios in turn
  initial begin
    {rst, tx_en, tx_er, tx_valid, refused} = 5'b10000;
    {enc_byp, scr_byp, descr_byp, dec_byp} = 4'h0;
    txd = 5'h00;
    sd_mode = 2'h0;
    repeat (4) @(negedge clk);
    check({5'h00, tx_pos, tx_neg, tx_ready}, 8'h00, 8'hFF);
    rst = 1'b0;
    t_pulses();
    t_data();
    t_halt();
    t_encbyp();
    t_allbyp();
    final_report();
  end
endmodule : tb
`default_nettype wire
